//--- bpoc_map.svh
`ifndef BPOC_MAP_SVH
`define BPOC_MAP_SVH

// Register offset (byte address) and layout
`define BPOC_OFF_PORT_OPT 12'h074
`define BPOC_OPT_RESET 12'hc6a
`define BPOC_OPT_RW_MASK 12'hffe
`define BPOC_OPT_W 12

// Field positions of port_option_control
`define BPOC_BIT_RSVD 0
`define BPOC_BIT_P_RD_ALIAS 1
`define BPOC_BIT_P_WR_ALIAS 2
`define BPOC_BIT_S_RD_ALIAS 3
`define BPOC_BIT_S_WR_ALIAS 4
`define BPOC_BIT_P_LM_ALIAS 5
`define BPOC_BIT_S_LM_ALIAS 6
`define BPOC_BIT_P_MWI_KEEP 7
`define BPOC_BIT_S_MWI_KEEP 8
`define BPOC_BIT_LONG_LOCK 9
`define BPOC_BIT_S_HOLD_REQ 10
`define BPOC_BIT_P_HOLD_REQ 11

// PCI memory command codes
`define BPOC_CMD_MEMR 4'h6
`define BPOC_CMD_MEMW 4'h7
`define BPOC_CMD_MEMRM 4'hc
`define BPOC_CMD_MEMRL 4'he
`define BPOC_CMD_MEMWI 4'hf

`endif

//--- bpoc_pkg.sv
`default_nettype none
package bpoc_pkg;

    typedef enum logic [1:0] {
        HOLD_IDLE,
        HOLD_REQ,
        HOLD_OWN,
        HOLD_WAIT
    } bpoc_hold_state_type;

    typedef struct packed {
        bpoc_hold_state_type state;
        logic req;
    } bpoc_hold_st_type;

    typedef struct packed {
        logic valid;
        logic match;
    } bpoc_match_st_type;

    typedef struct packed {
        logic [11:0] opt;
        logic [31:0] rdata;
        logic slverr;
        logic p_dst_valid;
        logic [3:0] p_dst_cmd;
        logic s_dst_valid;
        logic [3:0] s_dst_cmd;
    } bpoc_top_st_type;

endpackage
`default_nettype wire

//--- bpoc_retry_match.sv
`timescale 1ns/1ns
`default_nettype none
`include "bpoc_map.svh"

module bpoc_retry_match (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Alias options
    input wire logic rd_alias,
    input wire logic wr_alias,
    input wire logic lm_alias,
    // Retry query
    input wire logic rty_valid,
    input wire logic [3:0] rty_cmd,
    input wire logic [3:0] queued_cmd,
    // Result, one cycle after the query
    output logic rty_done,
    output logic rty_match
);

    bpoc_pkg::bpoc_match_st_type st_q;
    bpoc_pkg::bpoc_match_st_type st_d;

    function automatic logic cmd_match(input logic [3:0] rty,
                                       input logic [3:0] q,
                                       input logic rd, input logic wr,
                                       input logic lm);
        logic rd_lm;
        logic hit;
        rd_lm = (rty == `BPOC_CMD_MEMRL) || (rty == `BPOC_CMD_MEMRM);
        hit = (rty == q);
        if (rd && rd_lm && q == `BPOC_CMD_MEMR) begin
            hit = 1'b1;
        end
        if (lm && rd_lm && (q == `BPOC_CMD_MEMRL || q == `BPOC_CMD_MEMRM)) begin
            hit = 1'b1;
        end
        if (wr && rty == `BPOC_CMD_MEMWI && q == `BPOC_CMD_MEMW) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    always_comb begin
        st_d.valid = rty_valid;
        st_d.match = rty_valid &&
            cmd_match(rty_cmd, queued_cmd, rd_alias, wr_alias, lm_alias);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rty_done = st_q.valid;
    assign rty_match = st_q.match;

    AST_RD_ALIAS: assert property (
        @(posedge pclk) disable iff (!presetn)
        rty_valid && rd_alias && queued_cmd == `BPOC_CMD_MEMR &&
        (rty_cmd == `BPOC_CMD_MEMRL || rty_cmd == `BPOC_CMD_MEMRM)
        |=> rty_done && rty_match)
        else $error("read alias retry did not match");

    AST_EXACT_ONLY: assert property (
        @(posedge pclk) disable iff (!presetn)
        rty_valid && !rd_alias && !wr_alias && !lm_alias &&
        rty_cmd != queued_cmd |=> rty_done && !rty_match)
        else $error("inexact command matched with aliasing off");

    AST_WR_ALIAS: assert property (
        @(posedge pclk) disable iff (!presetn)
        rty_valid && rty_cmd == `BPOC_CMD_MEMWI &&
        queued_cmd == `BPOC_CMD_MEMW |=> rty_match == $past(wr_alias))
        else $error("write alias match wrong");

endmodule
`default_nettype wire

//--- bpoc_req_hold.sv
`timescale 1ns/1ns
`default_nettype none

module bpoc_req_hold (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Option
    input wire logic hold_long,
    // Master status
    input wire logic pending,
    input wire logic frame_start,
    input wire logic target_term,
    input wire logic xfer_end,
    // Bus request pin, active low
    output logic req_n
);

    bpoc_pkg::bpoc_hold_st_type st_q;
    bpoc_pkg::bpoc_hold_st_type st_d;

    always_comb begin
        st_d = st_q;
        unique case (st_q.state)
            bpoc_pkg::HOLD_IDLE: begin
                if (pending) begin
                    st_d.state = bpoc_pkg::HOLD_REQ;
                end
            end
            bpoc_pkg::HOLD_REQ: begin
                if (frame_start) begin
                    // Short mode lets go of the request at FRAME#
                    st_d.state = hold_long ? bpoc_pkg::HOLD_OWN
                                           : bpoc_pkg::HOLD_WAIT;
                end else if (!pending) begin
                    st_d.state = bpoc_pkg::HOLD_IDLE;
                end
            end
            bpoc_pkg::HOLD_OWN: begin
                if (!pending || target_term) begin
                    st_d.state = bpoc_pkg::HOLD_WAIT;
                end
            end
            bpoc_pkg::HOLD_WAIT: begin
                if (xfer_end) begin
                    st_d.state = bpoc_pkg::HOLD_IDLE;
                end
            end
        endcase
        st_d.req = (st_d.state == bpoc_pkg::HOLD_REQ) ||
                   (st_d.state == bpoc_pkg::HOLD_OWN);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign req_n = !st_q.req;

    AST_SHORT_DROP: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_q.state == bpoc_pkg::HOLD_REQ && frame_start && !hold_long
        |=> req_n)
        else $error("request held after FRAME# in short mode");

    AST_LONG_KEEP: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_q.state == bpoc_pkg::HOLD_REQ && frame_start && hold_long &&
        pending |=> !req_n ##1 (req_n || (pending && !target_term)))
        else $error("long request not held while work pending");

endmodule
`default_nettype wire

//--- bpoc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "bpoc_map.svh"

////////////////////////////////////////////////////////////////////////////
// Operation
// - Bit 0 reserved, reads zero
// - Bit 1: primary line/multiple retry matches read
// - Bit 2: primary invalidate retry matches write
// - Bit 3: secondary line/multiple retry matches read
// - Bit 4: secondary invalidate retry matches write
// - Bit 5: primary line and multiple interchangeable
// - Bit 6: secondary line and multiple interchangeable
// - Bit 7 clear: primary invalidate becomes write
// - Bit 8 clear: secondary invalidate becomes write
// - Bit 9 enables long lock requests
// - Bit 10: secondary master holds request longer
// - Bit 11: primary master holds request longer
module bpoc_top #(
    parameter int ADDR_W = 12
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Primary retry matching
    input wire logic p_rty_valid,
    input wire logic [3:0] p_rty_cmd,
    input wire logic [3:0] p_queued_cmd,
    output logic p_rty_done,
    output logic p_rty_match,
    // Secondary retry matching
    input wire logic s_rty_valid,
    input wire logic [3:0] s_rty_cmd,
    input wire logic [3:0] s_queued_cmd,
    output logic s_rty_done,
    output logic s_rty_match,
    // Commands accepted on primary, issued on secondary
    input wire logic p_fwd_valid,
    input wire logic [3:0] p_fwd_cmd,
    output logic s_dst_valid,
    output logic [3:0] s_dst_cmd,
    // Commands accepted on secondary, issued on primary
    input wire logic s_fwd_valid,
    input wire logic [3:0] s_fwd_cmd,
    output logic p_dst_valid,
    output logic [3:0] p_dst_cmd,
    // Lock handling
    output logic long_lock_req_en,
    // Internal primary master
    input wire logic p_mst_pending,
    input wire logic p_mst_frame_start,
    input wire logic p_mst_target_term,
    input wire logic p_mst_xfer_end,
    output logic p_mst_req_n,
    // Internal secondary master
    input wire logic s_mst_pending,
    input wire logic s_mst_frame_start,
    input wire logic s_mst_target_term,
    input wire logic s_mst_xfer_end,
    output logic s_mst_req_n
);

    if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_chk
        $error("ADDR_W must lie between 8 and 32");
    end

    ////////////////////////////////////////////////////////////////////////
    // State

    bpoc_pkg::bpoc_top_st_type st_q;
    bpoc_pkg::bpoc_top_st_type st_d;
    logic hit;
    logic setup;
    logic wr_acc;
    logic [11:0] opt;

    // Invalidate is turned into plain write unless the keep bit is set
    function automatic logic [3:0] fwd_cmd(input logic [3:0] cmd,
                                           input logic keep);
        logic [3:0] res;
        res = cmd;
        if (cmd == `BPOC_CMD_MEMWI && !keep) begin
            res = `BPOC_CMD_MEMW;
        end
        return res;
    endfunction

    assign opt = st_q.opt;
    assign hit = (paddr == ADDR_W'(`BPOC_OFF_PORT_OPT));
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && hit;

    ////////////////////////////////////////////////////////////////////////
    // Register file and command forwarding

    always_comb begin
        st_d = st_q;
        // Read data and error are prepared in the setup cycle
        if (setup) begin
            st_d.rdata = (hit && !pwrite) ? {20'h0, opt} : 32'h0;
            st_d.slverr = !hit;
        end
        // Lane 0 carries bits 7:1, lane 1 bits 11:8; bit 0 stays zero
        if (wr_acc) begin
            if (pstrb[0]) begin
                st_d.opt[7:1] = pwdata[7:1];
            end
            if (pstrb[1]) begin
                st_d.opt[11:8] = pwdata[11:8];
            end
        end
        st_d.opt[`BPOC_BIT_RSVD] = 1'b0;
        st_d.s_dst_valid = p_fwd_valid;
        st_d.s_dst_cmd = fwd_cmd(p_fwd_cmd,
                                 opt[`BPOC_BIT_P_MWI_KEEP]);
        st_d.p_dst_valid = s_fwd_valid;
        st_d.p_dst_cmd = fwd_cmd(s_fwd_cmd,
                                 opt[`BPOC_BIT_S_MWI_KEEP]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.opt <= `BPOC_OPT_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign prdata = st_q.rdata;
    assign pslverr = st_q.slverr;
    assign s_dst_valid = st_q.s_dst_valid;
    assign s_dst_cmd = st_q.s_dst_cmd;
    assign p_dst_valid = st_q.p_dst_valid;
    assign p_dst_cmd = st_q.p_dst_cmd;
    assign long_lock_req_en = opt[`BPOC_BIT_LONG_LOCK];

    ////////////////////////////////////////////////////////////////////////
    // Retry matching per port

    bpoc_retry_match u_p_match (
        .pclk(pclk),
        .presetn(presetn),
        .rd_alias(opt[`BPOC_BIT_P_RD_ALIAS]),
        .wr_alias(opt[`BPOC_BIT_P_WR_ALIAS]),
        .lm_alias(opt[`BPOC_BIT_P_LM_ALIAS]),
        .rty_valid(p_rty_valid),
        .rty_cmd(p_rty_cmd),
        .queued_cmd(p_queued_cmd),
        .rty_done(p_rty_done),
        .rty_match(p_rty_match)
    );

    bpoc_retry_match u_s_match (
        .pclk(pclk),
        .presetn(presetn),
        .rd_alias(opt[`BPOC_BIT_S_RD_ALIAS]),
        .wr_alias(opt[`BPOC_BIT_S_WR_ALIAS]),
        .lm_alias(opt[`BPOC_BIT_S_LM_ALIAS]),
        .rty_valid(s_rty_valid),
        .rty_cmd(s_rty_cmd),
        .queued_cmd(s_queued_cmd),
        .rty_done(s_rty_done),
        .rty_match(s_rty_match)
    );

    ////////////////////////////////////////////////////////////////////////
    // Request holding of the internal masters

    bpoc_req_hold u_p_hold (
        .pclk(pclk),
        .presetn(presetn),
        .hold_long(opt[`BPOC_BIT_P_HOLD_REQ]),
        .pending(p_mst_pending),
        .frame_start(p_mst_frame_start),
        .target_term(p_mst_target_term),
        .xfer_end(p_mst_xfer_end),
        .req_n(p_mst_req_n)
    );

    bpoc_req_hold u_s_hold (
        .pclk(pclk),
        .presetn(presetn),
        .hold_long(opt[`BPOC_BIT_S_HOLD_REQ]),
        .pending(s_mst_pending),
        .frame_start(s_mst_frame_start),
        .target_term(s_mst_target_term),
        .xfer_end(s_mst_xfer_end),
        .req_n(s_mst_req_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_RSVD_ZERO: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && hit |-> prdata[0] == 1'b0 &&
        prdata[31:12] == 20'h0)
        else $error("reserved bits read nonzero");

    AST_READBACK: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && pstrb[1:0] == 2'b11 ##1 psel && !penable && !pwrite && hit
        ##1 penable |-> prdata[11:1] == $past(pwdata[11:1], 2))
        else $error("written value not read back");

    AST_READ_DATA: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && hit |-> prdata[11:0] == opt)
        else $error("read data differs from register");

    AST_WR_APPLY: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && pstrb[0] && !pwdata[`BPOC_BIT_P_RD_ALIAS] |=>
        !opt[`BPOC_BIT_P_RD_ALIAS] && !u_p_match.rd_alias)
        else $error("write did not take effect at completion");

    AST_LANE0_WRITE: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && pstrb[0] |=> opt[7:1] == $past(pwdata[7:1]))
        else $error("lane 0 write not stored");

    AST_LANE0_KEEP: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && !pstrb[0] |=> opt[7:0] == $past(opt[7:0]))
        else $error("lane 0 changed without its strobe");

    AST_LANE1_KEEP: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && !pstrb[1] |=> opt[11:8] == $past(opt[11:8]))
        else $error("lane 1 changed without its strobe");

    AST_UNMAPPED: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !hit |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");

    AST_P_MWI: assert property (
        @(posedge pclk) disable iff (!presetn)
        p_fwd_valid && p_fwd_cmd == `BPOC_CMD_MEMWI |=> s_dst_valid &&
        s_dst_cmd == ($past(opt[`BPOC_BIT_P_MWI_KEEP]) ? `BPOC_CMD_MEMWI
                                                        : `BPOC_CMD_MEMW))
        else $error("primary invalidate forwarded wrongly");

    AST_P_FWD_PASS: assert property (
        @(posedge pclk) disable iff (!presetn)
        p_fwd_valid && p_fwd_cmd != `BPOC_CMD_MEMWI |=> s_dst_valid &&
        s_dst_cmd == $past(p_fwd_cmd))
        else $error("primary command altered in forwarding");

    AST_DST_IDLE: assert property (
        @(posedge pclk) disable iff (!presetn)
        !p_fwd_valid |=> !s_dst_valid)
        else $error("secondary issue without accepted command");

    AST_S_MWI: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_fwd_valid && s_fwd_cmd == `BPOC_CMD_MEMWI &&
        !opt[`BPOC_BIT_S_MWI_KEEP] |=> p_dst_valid &&
        p_dst_cmd == `BPOC_CMD_MEMW)
        else $error("secondary invalidate not converted");

    AST_S_MWI_KEEP: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_fwd_valid && s_fwd_cmd == `BPOC_CMD_MEMWI &&
        opt[`BPOC_BIT_S_MWI_KEEP] |=> p_dst_valid && p_dst_cmd == 4'hf)
        else $error("secondary invalidate converted while kept");

    AST_S_FWD_PASS: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_fwd_valid && s_fwd_cmd != `BPOC_CMD_MEMWI |=> p_dst_valid &&
        p_dst_cmd == $past(s_fwd_cmd))
        else $error("secondary command altered in forwarding");

    AST_DST_IDLE_S: assert property (
        @(posedge pclk) disable iff (!presetn)
        !s_fwd_valid |=> !p_dst_valid)
        else $error("primary issue without accepted command");

    AST_LOCK: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && pstrb[1] |=> long_lock_req_en ==
        $past(pwdata[`BPOC_BIT_LONG_LOCK]))
        else $error("long lock enable not following write");

    AST_NO_WR_KEEP: assert property (
        @(posedge pclk) disable iff (!presetn)
        !wr_acc |=> opt == $past(opt))
        else $error("option register changed without write");

endmodule
`default_nettype wire

//--- bpoc_pci_model.sv
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Bus-side activity of one internal master: work arrives, the bus is won,
// FRAME# goes out, and the transaction ends normally or by target stop
module bpoc_pci_model (
    // Clock and test control
    input wire logic pclk,
    input wire logic start,
    input wire logic abort,
    input wire logic [1:0] gap,
    // Request from the bridge, active low
    input wire logic req_n,
    // Master status towards the bridge
    output logic pending,
    output logic frame_start,
    output logic target_term,
    output logic xfer_end
);
    initial begin
        pending = 1'b0;
        frame_start = 1'b0;
        target_term = 1'b0;
        xfer_end = 1'b0;
        forever begin
            @(posedge pclk);
            if (start) begin
                pending <= 1'b1;
                do @(posedge pclk); while (req_n !== 1'b0);
                repeat (gap) @(posedge pclk);
                frame_start <= 1'b1;
                @(posedge pclk);
                frame_start <= 1'b0;
                repeat (3) @(posedge pclk);
                // Either the target stops us or the FIFO runs dry
                if (abort) begin
                    target_term <= 1'b1;
                end else begin
                    pending <= 1'b0;
                end
                @(posedge pclk);
                target_term <= 1'b0;
                pending <= 1'b0;
                xfer_end <= 1'b1;
                @(posedge pclk);
                xfer_end <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- bridge_port_option_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "bpoc_map.svh"

module bridge_port_option_control_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [1:0] rty_valid = 2'h0;
    logic [1:0] fwd_valid = 2'h0;
    logic [3:0] rty_cmd [2] = '{4'h0, 4'h0};
    logic [3:0] q_cmd [2] = '{4'h0, 4'h0};
    logic [3:0] fwd_cmd [2] = '{4'h0, 4'h0};
    logic [1:0] rty_done, rty_match, dst_valid;
    logic [3:0] dst_cmd [2];
    logic long_lock_req_en;
    logic [1:0] start = 2'h0;
    logic abort = 1'b0;
    logic [1:0] gap = 2'h0;
    logic [1:0] pend, fs, tt, xe, req_n;
    logic [3:0] cmds [5] = '{`BPOC_CMD_MEMR, `BPOC_CMD_MEMW,
        `BPOC_CMD_MEMRM, `BPOC_CMD_MEMRL, `BPOC_CMD_MEMWI};
    int opt;
    int seed;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] r;

    always #4 pclk = ~pclk;

    bpoc_top i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .p_rty_valid(rty_valid[0]), .p_rty_cmd(rty_cmd[0]),
        .p_queued_cmd(q_cmd[0]), .p_rty_done(rty_done[0]),
        .p_rty_match(rty_match[0]),
        .s_rty_valid(rty_valid[1]), .s_rty_cmd(rty_cmd[1]),
        .s_queued_cmd(q_cmd[1]), .s_rty_done(rty_done[1]),
        .s_rty_match(rty_match[1]),
        .p_fwd_valid(fwd_valid[0]), .p_fwd_cmd(fwd_cmd[0]),
        .s_dst_valid(dst_valid[0]), .s_dst_cmd(dst_cmd[0]),
        .s_fwd_valid(fwd_valid[1]), .s_fwd_cmd(fwd_cmd[1]),
        .p_dst_valid(dst_valid[1]), .p_dst_cmd(dst_cmd[1]),
        .long_lock_req_en(long_lock_req_en),
        .p_mst_pending(pend[0]), .p_mst_frame_start(fs[0]),
        .p_mst_target_term(tt[0]), .p_mst_xfer_end(xe[0]),
        .p_mst_req_n(req_n[0]),
        .s_mst_pending(pend[1]), .s_mst_frame_start(fs[1]),
        .s_mst_target_term(tt[1]), .s_mst_xfer_end(xe[1]),
        .s_mst_req_n(req_n[1])
    );

    bpoc_pci_model i_pm (
        .pclk(pclk), .start(start[0]), .abort(abort), .gap(gap),
        .req_n(req_n[0]), .pending(pend[0]), .frame_start(fs[0]),
        .target_term(tt[0]), .xfer_end(xe[0])
    );

    bpoc_pci_model i_sm (
        .pclk(pclk), .start(start[1]), .abort(abort), .gap(gap),
        .req_n(req_n[1]), .pending(pend[1]), .frame_start(fs[1]),
        .target_term(tt[1]), .xfer_end(xe[1])
    );

    ////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
             input logic [3:0] sb, input logic last,
             output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= sb;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // Unless last, select stays up: the next setup follows at once
        penable <= 1'b0;
        if (last) begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task wr_opt(input logic [11:0] a, input logic [31:0] wd,
                input logic [3:0] sb);
        int m;
        logic [31:0] rd;
        logic err;
        m = (sb[0] ? 'hff : 0) | (sb[1] ? 'hf00 : 0);
        apb(1'b1, a, wd, sb, 1'b0, rd, err);
        if (a == `BPOC_OFF_PORT_OPT) opt = (opt & ~m) | (wd & m & 'hffe);
        chk(err, a != `BPOC_OFF_PORT_OPT);
    endtask

    task rd_opt(input logic [11:0] a);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, 4'h0, 1'b1, rd, err);
        chk(rd, a == `BPOC_OFF_PORT_OPT ? opt : 0);
        chk(err, a != `BPOC_OFF_PORT_OPT);
        chk(long_lock_req_en, opt[9]);
    endtask

    function logic exp_match(input int p, input logic [3:0] c, input logic [3:0] q);
        logic rl;
        logic ql;
        rl = c == `BPOC_CMD_MEMRL || c == `BPOC_CMD_MEMRM;
        ql = q == `BPOC_CMD_MEMRL || q == `BPOC_CMD_MEMRM;
        return c == q || (opt[p ? 3 : 1] && rl && q == `BPOC_CMD_MEMR) ||
            (opt[p ? 6 : 5] && rl && ql) || (opt[p ? 4 : 2] &&
            c == `BPOC_CMD_MEMWI && q == `BPOC_CMD_MEMW);
    endfunction

    task query(input int p, input logic [3:0] c, input logic [3:0] q,
               input logic [3:0] f);
        rty_valid[p] <= 1'b1;
        rty_cmd[p] <= c;
        q_cmd[p] <= q;
        fwd_valid[p] <= 1'b1;
        fwd_cmd[p] <= f;
        @(posedge pclk);
        rty_valid[p] <= 1'b0;
        fwd_valid[p] <= 1'b0;
        @(posedge pclk);
        chk(rty_done[p], 1);
        chk(rty_match[p], exp_match(p, c, q));
        chk(dst_valid[p], 1);
        chk(dst_cmd[p], (f == `BPOC_CMD_MEMWI && !opt[7 + p]) ? `BPOC_CMD_MEMW : f);
    endtask

    task mst(input int p);
        int n;
        start[p] <= 1'b1;
        @(posedge pclk);
        start[p] <= 1'b0;
        n = 0;
        do begin @(posedge pclk); n++; end while (fs[p] !== 1'b1 && n < 50);
        chk(req_n[p], 0);
        @(posedge pclk);
        chk(req_n[p], !opt[11 - p]);
        n = 0;
        do begin @(posedge pclk); n++; end while (xe[p] !== 1'b1 && n < 50);
        chk(req_n[p], 1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 35259;
        opt = 'hc6a;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_opt(`BPOC_OFF_PORT_OPT);
        wr_opt(`BPOC_OFF_PORT_OPT, 32'hffffffff, 4'hf);
        rd_opt(`BPOC_OFF_PORT_OPT);
        wr_opt(12'h078, 32'h0, 4'hf);
        rd_opt(12'h078);
        rd_opt(`BPOC_OFF_PORT_OPT);
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            wr_opt(`BPOC_OFF_PORT_OPT, r, r[15:12]);
            rd_opt(`BPOC_OFF_PORT_OPT);
            repeat (6) begin
                r = $random(seed);
                query(r[0], cmds[r[3:1] % 5], cmds[r[6:4] % 5], cmds[r[9:7] % 5]);
            end
            abort <= r[10];
            gap <= r[12:11];
            mst(r[13]);
        end
        end_sim();
    end
endmodule
`default_nettype wire
